// ### src/irq_pm_pkg.sv
/*
 * Package for the interrupt enable/priority and power-mode block:
 * register offsets, field positions, reset values, states and timing.
 * Assumes a 250 MHz system clock.
 */
package irq_pm_pkg;

    // ========================================================
    // register offsets
    localparam logic [7:0] OFS_IRQ_ENABLE_MASK   = 8'ha8;
    localparam logic [7:0] OFS_IRQ_PRIORITY_HIGH = 8'hb7;
    localparam logic [7:0] OFS_IRQ_PRIORITY_LOW  = 8'hb8;
    localparam logic [7:0] OFS_PM_CONTROL        = 8'h87;
    localparam logic [7:0] OFS_AUX_CONTROL       = 8'h8e;
    localparam logic [7:0] OFS_PM_STATUS         = 8'h8f;

    // ========================================================
    // field positions and masks
    localparam int         BIT_GLOBAL_EN   = 7;
    localparam int         BIT_IDLE_REQ    = 0;
    localparam int         BIT_PDOWN_REQ   = 1;
    localparam int         BIT_WAKE_EDGE   = 1;
    localparam logic [7:0] IE_WRITE_MASK   = 8'hbf;
    localparam logic [7:0] PRIO_WRITE_MASK = 8'h3f;
    localparam logic [7:0] AUX_WRITE_MASK  = 8'h02;
    localparam logic [7:0] RESET_ZERO      = 8'h00;

    // sources in fixed order: ext0, timer0, ext1, timer1, serial, timer2
    localparam int         NUM_SRC  = 6;
    localparam int         SRC_EXT0   = 0;
    localparam int         SRC_TIMER0 = 1;
    localparam int         SRC_EXT1   = 2;
    localparam int         SRC_TIMER1 = 3;
    localparam int         SRC_SERIAL = 4;
    localparam int         SRC_TIMER2 = 5;
    localparam logic [2:0] NO_SRC   = 3'h7;

    // ========================================================
    // timing
    localparam int CLK_MHZ          = 250;
    localparam int WAKE_DELAY_US    = 2000;
    localparam int WAKE_DELAY_CYC   = WAKE_DELAY_US * CLK_MHZ;
    localparam int RESET_WINDOW_CYC = 24;
    localparam int CNT_W            = 20;

    typedef enum logic [1:0] {
        PM_RUN,
        PM_IDLE,
        PM_PDOWN,
        PM_WAKE_WAIT
    } pm_state_t;

endpackage

// ### src/irq_enable_priority_power_modes.sv
/*
 * Interrupt enable, four-level priority selection, idle and power-down
 * control for an 8-bit core. Registers on a plain strobe port.
 * Assumes synchronous request inputs and an active-low async reset that
 * the core holds until its oscillator is stable.
 */
`timescale 1ns/1ps
`default_nettype none


module irq_enable_priority_power_modes
    import irq_pm_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_DELAY_CYC
)(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       hw_reset_req,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // interrupt sources, flags held by their owners
    input  wire logic       ext0_req,
    input  wire logic       timer0_req,
    input  wire logic       ext1_req,
    input  wire logic       timer1_req,
    input  wire logic       uart_rx_flag,
    input  wire logic       uart_tx_flag,
    input  wire logic       spi_done_flag,
    input  wire logic       spi_irq_enable,
    input  wire logic       timer2_overflow_flag,
    input  wire logic       timer2_external_flag,
    input  wire logic       ext0_pin,
    input  wire logic       ext1_pin,
    // cpu side
    input  wire logic       irq_ack,
    input  wire logic       ext_prog_mem,
    output logic            irq_valid,
    output logic      [2:0] irq_source,
    output logic      [1:0] irq_level,
    output logic            cpu_halt,
    output logic            osc_stop,
    output logic            ram_access_block,
    output logic            ale_out,
    output logic            prog_fetch_strobe,
    output logic            port0_float,
    output logic            port2_addr_drive
);

    // ========================================================
    // state
    typedef struct packed {
        logic [7:0]       ie;
        logic [7:0]       irq_priority_high;
        logic [7:0]       ipl;
        logic             wake_edge_select;
        pm_state_t        pm;
        logic [CNT_W-1:0] cnt;
        logic [4:0]       rst_win;
        logic [1:0]       wake_src;
        logic             pin_q;
        logic [7:0]       rdata;
        logic [2:0]       src;
        logic [1:0]       lvl;
        logic             valid;
    } state_t;

    state_t s_q;
    state_t s_d;

    localparam logic [CNT_W-1:0] WAKE_CNT = CNT_W'(WAKE_CYCLES - 1);

    // level of one source from its high and low bits
    function automatic logic [1:0] prio_level(input logic hi, input logic lo);
        prio_level = {hi, lo};
    endfunction

    // ========================================================
    // named register fields
    // enable fields
    logic               global_irq_enable;
    logic               timer2_irq_enable;
    logic               serial_irq_enable;
    logic               timer1_irq_enable;
    logic               ext1_irq_enable;
    logic               timer0_irq_enable;
    logic               ext0_irq_enable;

    // priority fields
    logic               timer2_prio_high;
    logic               serial_prio_high;
    logic               timer1_prio_high;
    logic               ext1_prio_high;
    logic               timer0_prio_high;
    logic               ext0_prio_high;
    logic               timer2_prio_low;
    logic               serial_prio_low;
    logic               timer1_prio_low;
    logic               ext1_prio_low;
    logic               timer0_prio_low;
    logic               ext0_prio_low;

    logic [NUM_SRC-1:0] src_en;
    logic [1:0]         src_lvl [NUM_SRC];

    always_comb
    begin
        // enable fields; reserved bit 6 never reaches a source
        global_irq_enable = s_q.ie[BIT_GLOBAL_EN];
        timer2_irq_enable = s_q.ie[SRC_TIMER2];
        serial_irq_enable = s_q.ie[SRC_SERIAL];
        timer1_irq_enable = s_q.ie[SRC_TIMER1];
        ext1_irq_enable   = s_q.ie[SRC_EXT1];
        timer0_irq_enable = s_q.ie[SRC_TIMER0];
        ext0_irq_enable   = s_q.ie[SRC_EXT0];

        // priority fields share one bit layout in both registers
        timer2_prio_high  = s_q.irq_priority_high[SRC_TIMER2];
        serial_prio_high  = s_q.irq_priority_high[SRC_SERIAL];
        timer1_prio_high  = s_q.irq_priority_high[SRC_TIMER1];
        ext1_prio_high    = s_q.irq_priority_high[SRC_EXT1];
        timer0_prio_high  = s_q.irq_priority_high[SRC_TIMER0];
        ext0_prio_high    = s_q.irq_priority_high[SRC_EXT0];
        timer2_prio_low   = s_q.ipl[SRC_TIMER2];
        serial_prio_low   = s_q.ipl[SRC_SERIAL];
        timer1_prio_low   = s_q.ipl[SRC_TIMER1];
        ext1_prio_low     = s_q.ipl[SRC_EXT1];
        timer0_prio_low   = s_q.ipl[SRC_TIMER0];
        ext0_prio_low     = s_q.ipl[SRC_EXT0];

        src_en = {timer2_irq_enable, serial_irq_enable, timer1_irq_enable,
                  ext1_irq_enable, timer0_irq_enable, ext0_irq_enable};
        src_lvl[SRC_EXT0]   = prio_level(ext0_prio_high, ext0_prio_low);
        src_lvl[SRC_TIMER0] = prio_level(timer0_prio_high, timer0_prio_low);
        src_lvl[SRC_EXT1]   = prio_level(ext1_prio_high, ext1_prio_low);
        src_lvl[SRC_TIMER1] = prio_level(timer1_prio_high, timer1_prio_low);
        src_lvl[SRC_SERIAL] = prio_level(serial_prio_high, serial_prio_low);
        src_lvl[SRC_TIMER2] = prio_level(timer2_prio_high, timer2_prio_low);
    end

    // ========================================================
    // request gating and arbitration
    logic [NUM_SRC-1:0] raw_req;
    logic [NUM_SRC-1:0] gated_req;
    logic               serial_req;
    logic               timer2_req;
    logic               wake_pin_low;
    logic [2:0]         best_src;
    logic [1:0]         best_lvl;
    logic               best_ok;

    always_comb
    begin
        serial_req = uart_rx_flag | uart_tx_flag | (spi_done_flag & spi_irq_enable);
        timer2_req = timer2_overflow_flag | timer2_external_flag;
        raw_req    = {timer2_req, serial_req, timer1_req, ext1_req, timer0_req, ext0_req};
        // per-source bits 0..5 line up with sources; bit 4 gates serial
        gated_req  = raw_req & src_en & {NUM_SRC{global_irq_enable}};
        best_src   = NO_SRC;
        best_lvl   = 2'h0;
        best_ok    = 1'b0;
        // ascending scan with strict compare keeps the earlier source on ties
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (gated_req[i] && (!best_ok || src_lvl[i] > best_lvl))
            begin
                best_ok  = 1'b1;
                best_lvl = src_lvl[i];
                best_src = 3'(i);
            end
        end
        wake_pin_low = (s_q.wake_src[0] & !ext0_pin) | (s_q.wake_src[1] & !ext1_pin);
    end

    // ========================================================
    // next state
    always_comb
    begin
        s_d       = s_q;
        s_d.rdata = RESET_ZERO;
        if (s_q.rst_win != 5'h0)
        begin
            s_d.rst_win = s_q.rst_win - 5'h1;
        end

        // register writes; reserved bits stay zero
        if (reg_wr)
        begin
            unique case (reg_addr)
                OFS_IRQ_ENABLE_MASK:   s_d.ie  = reg_wdata & IE_WRITE_MASK;
                OFS_IRQ_PRIORITY_HIGH: s_d.irq_priority_high = reg_wdata & PRIO_WRITE_MASK;
                OFS_IRQ_PRIORITY_LOW:  s_d.ipl = reg_wdata & PRIO_WRITE_MASK;
                OFS_AUX_CONTROL:       s_d.wake_edge_select = reg_wdata[BIT_WAKE_EDGE];
                default:               s_d.ie  = s_q.ie;
            endcase
        end

        // register reads, one cycle later; unmapped reads zero
        if (reg_rd)
        begin
            unique case (reg_addr)
                OFS_IRQ_ENABLE_MASK:   s_d.rdata = s_q.ie;
                OFS_IRQ_PRIORITY_HIGH: s_d.rdata = s_q.irq_priority_high;
                OFS_IRQ_PRIORITY_LOW:  s_d.rdata = s_q.ipl;
                OFS_AUX_CONTROL:       s_d.rdata = {6'h0, s_q.wake_edge_select, 1'b0};
                OFS_PM_STATUS:         s_d.rdata = {6'h0, s_q.pm};
                default:               s_d.rdata = RESET_ZERO;
            endcase
        end

        // request to the core; the core clears source flags itself
        s_d.valid = best_ok && (s_q.pm == PM_RUN);
        s_d.src   = best_ok ? best_src : NO_SRC;
        s_d.lvl   = best_lvl;

        unique case (s_q.pm)
            PM_RUN:
            begin
                if (reg_wr && reg_addr == OFS_PM_CONTROL)
                begin
                    if (reg_wdata[BIT_PDOWN_REQ])
                    begin
                        s_d.pm       = PM_PDOWN;
                        s_d.wake_src = {s_q.ie[SRC_EXT1], s_q.ie[SRC_EXT0]}
                                       & {2{s_q.ie[BIT_GLOBAL_EN]}};
                    end
                    else if (reg_wdata[BIT_IDLE_REQ])
                    begin
                        s_d.pm = PM_IDLE;
                    end
                end
            end
            PM_IDLE:
            begin
                if (best_ok)
                begin
                    s_d.pm = PM_RUN;
                end
            end
            PM_PDOWN:
            begin
                // only an enabled external pin held low can wake
                if (wake_pin_low)
                begin
                    s_d.pm  = PM_WAKE_WAIT;
                    s_d.cnt = WAKE_CNT;
                end
            end
            PM_WAKE_WAIT:
            begin
                if (s_q.wake_edge_select)
                begin
                    if (!wake_pin_low && s_q.pin_q)
                    begin
                        s_d.pm = PM_RUN;
                    end
                end
                else if (s_q.cnt == '0)
                begin
                    s_d.pm = PM_RUN;
                end
                else
                begin
                    s_d.cnt = s_q.cnt - CNT_W'(1);
                end
            end
        endcase
        s_d.pin_q = wake_pin_low;

        // reset request ending idle: short window with ram blocked
        if (hw_reset_req && s_q.pm == PM_IDLE)
        begin
            s_d.pm      = PM_RUN;
            s_d.rst_win = 5'(RESET_WINDOW_CYC);
        end
    end

    // ========================================================
    // registers; reset reinitialises only this block's state
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q       <= '0;
            s_q.pm    <= PM_RUN;
            s_q.src   <= NO_SRC;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ========================================================
    // outputs
    // strobes high only in idle; power-down and wake-wait keep them low
    // port 0 floats whenever halted with external program memory
    assign reg_rdata         = s_q.rdata;
    assign irq_valid         = s_q.valid & ~irq_ack;
    assign irq_source        = s_q.src;
    assign irq_level         = s_q.lvl;
    assign cpu_halt          = s_q.pm != PM_RUN;
    assign osc_stop          = s_q.pm == PM_PDOWN;
    assign ram_access_block  = s_q.rst_win != 5'h0;
    assign ale_out           = s_q.pm == PM_IDLE;
    assign prog_fetch_strobe = s_q.pm == PM_IDLE;
    assign port0_float       = ext_prog_mem & (s_q.pm != PM_RUN);
    assign port2_addr_drive  = ext_prog_mem & (s_q.pm == PM_IDLE);

endmodule

`default_nettype wire

// ### bench/irq_pm_sva.sv
/* port checker for the interrupt enable, priority and power-mode block.
   bound to the block; sees only its top-level ports. */
`timescale 1ns/1ps
`default_nettype none
module irq_pm_sva
    import irq_pm_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       hw_reset_req,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins and core side
    input wire logic       ext0_pin,
    input wire logic       ext1_pin,
    input wire logic       irq_ack,
    input wire logic       ext_prog_mem,
    input wire logic       irq_valid,
    input wire logic [2:0] irq_source,
    input wire logic [1:0] irq_level,
    input wire logic       cpu_halt,
    input wire logic       osc_stop,
    input wire logic       ram_access_block,
    input wire logic       ale_out,
    input wire logic       prog_fetch_strobe,
    input wire logic       port0_float,
    input wire logic       port2_addr_drive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] blk_q;
    // counts cycles of the ram block window
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            blk_q <= 8'h00;
        else
            blk_q <= ram_access_block ? blk_q + 8'h01 : 8'h00;
    // ========================================
    // assertions
    rdata_slot_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    mask_back_a: assert property ((reg_wr && reg_addr == OFS_IRQ_ENABLE_MASK) ##2
        (reg_rd && reg_addr == OFS_IRQ_ENABLE_MASK) |=> reg_rdata == ($past(reg_wdata, 3) & IE_WRITE_MASK))
        else $error("enable mask readback wrong");
    ack_mask_a: assert property (irq_ack |-> !irq_valid)
        else $error("request shown during acknowledge");
    src_range_a: assert property (irq_valid |-> irq_source <= 3'h5)
        else $error("winner out of range");
    halt_quiet_a: assert property (cpu_halt && $past(cpu_halt) |-> !irq_valid)
        else $error("request shown while halted");
    pdown_pins_a: assert property (osc_stop |-> !ale_out && !prog_fetch_strobe && cpu_halt)
        else $error("strobes not low in power-down");
    idle_entry_a: assert property ($rose(ale_out) |-> $past(reg_wr) && $past(reg_addr) == OFS_PM_CONTROL)
        else $error("strobes high without idle request");
    port_state_a: assert property (port0_float == (ext_prog_mem && cpu_halt)
        && port2_addr_drive == (ext_prog_mem && ale_out))
        else $error("port float or address drive wrong");
    wake_cause_a: assert property ($fell(osc_stop) |-> !$past(ext0_pin) || !$past(ext1_pin))
        else $error("power-down left without pin");
    ram_start_a: assert property ($rose(ram_access_block) |-> $past(hw_reset_req) && !cpu_halt)
        else $error("ram block without reset from idle");
    ram_len_a: assert property ($fell(ram_access_block) |-> blk_q == RESET_WINDOW_CYC)
        else $error("ram block window length wrong");
    cover property (irq_valid && irq_level == 2'h3);
    cover property ($fell(osc_stop));
    cover property ($fell(ram_access_block));
endmodule
bind irq_enable_priority_power_modes irq_pm_sva chk (.*);
`default_nettype wire

// ### bench/cpu_model.sv
/* core-side model: acknowledges a held request after ACK_DLY cycles
   while ack_en is high; shares the block's clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module cpu_model #(
    parameter int ACK_DLY = 4
)(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // request handshake
    input  wire logic ack_en,
    input  wire logic irq_valid,
    output var  logic irq_ack
);
    logic [7:0] wait_q;
    // registered ack: a combinational one would loop through the masked valid
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            wait_q  <= 8'h00;
            irq_ack <= 1'b0;
        end
        else
        begin
            wait_q  <= irq_valid ? wait_q + 8'h01 : 8'h00;
            irq_ack <= ack_en && irq_valid && wait_q == 8'(ACK_DLY - 1);
        end
endmodule
`default_nettype wire

// ### bench/testbench.sv
/* self-checking bench: registers, gating, priority, idle, power-down.
   assumes the package, block, checker and core model compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import irq_pm_pkg::*;
;
    logic       clk = 0, rst_n = 0, hw_reset_req = 0, reg_wr = 0, reg_rd = 0, ack_en = 0;
    logic       ext0_pin = 1, ext1_pin = 1, ext_prog_mem = 0, uart_tx_flag = 0, spi_done_flag = 0;
    logic       spi_irq_enable = 0, timer2_external_flag = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [5:0] req = 0;
    logic       irq_valid, irq_ack, cpu_halt, osc_stop, ram_access_block;
    logic       ale_out, prog_fetch_strobe, port0_float, port2_addr_drive;
    logic [2:0] irq_source;
    logic [1:0] irq_level;
    wire        ext0_req = req[0], timer0_req = req[1], ext1_req = req[2];
    wire        timer1_req = req[3], uart_rx_flag = req[4], timer2_overflow_flag = req[5];
    int         err_count = 0, n_compared = 0, n;
    logic [7:0] ofs[4] = '{OFS_IRQ_ENABLE_MASK, OFS_IRQ_PRIORITY_HIGH, OFS_IRQ_PRIORITY_LOW, 8'h10};
    logic [7:0] msk[4] = '{8'hbf, 8'h3f, 8'h3f, 8'h00};
    localparam int PDOWN_LOCKOUT_CYC = 4 * CLK_MHZ;
    // short wake count keeps the run brief
    irq_enable_priority_power_modes #(.WAKE_CYCLES(20)) dut (.*);
    cpu_model #(.ACK_DLY(4)) core (.*);
    always #2 clk = ~clk;
    // ========================================
    // access tasks
    task chk(input logic [7:0] g, e);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // result packed as level, valid, source
    task irq(input logic [5:0] r, input logic [7:0] e);
        @(posedge clk);
        req <= r;
        repeat (3) @(posedge clk);
        #1 chk(irq_valid ? {2'h0, irq_level, 1'b1, irq_source} : 8'h00, e);
    endtask
    task stop_test;
        $display("compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ========================================
    // tests
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(ofs[i], 8'hff);
            rd(ofs[i], msk[i]);
        end
        irq(6'h3f, 8'h38);
        wr(OFS_IRQ_PRIORITY_HIGH, 8'h22);
        wr(OFS_IRQ_PRIORITY_LOW, 8'h30);
        irq(6'h3f, 8'h3d);
        irq(6'h1d, 8'h1c);
        irq(6'h0f, 8'h29);
        irq(6'h0c, 8'h0a);
        $display("priority done");
        wr(OFS_IRQ_PRIORITY_HIGH, 8'h00);
        wr(OFS_IRQ_PRIORITY_LOW, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            wr(OFS_IRQ_ENABLE_MASK, 8'h80 | (8'h01 << i));
            irq(6'h3f, {5'h01, i[2:0]});
            wr(OFS_IRQ_ENABLE_MASK, 8'h01 << i);
            irq(6'h3f, 8'h00);
        end
        $display("gating done");
        wr(OFS_IRQ_ENABLE_MASK, 8'hb0);
        spi_done_flag <= 1'b1;
        irq(6'h00, 8'h00);
        spi_irq_enable <= 1'b1;
        irq(6'h00, 8'h0c);
        spi_done_flag <= 1'b0;
        uart_tx_flag <= 1'b1;
        timer2_external_flag <= 1'b1;
        irq(6'h00, 8'h0c);
        uart_tx_flag <= 1'b0;
        irq(6'h00, 8'h0d);
        ack_en <= 1'b1;
        repeat (12) @(posedge clk);
        ack_en <= 1'b0;
        timer2_external_flag <= 1'b0;
        $display("shared request done");
        wr(OFS_IRQ_ENABLE_MASK, 8'h81);
        ext_prog_mem <= 1'b1;
        wr(OFS_PM_CONTROL, 8'h01);
        #1 chk({3'h0, cpu_halt, ale_out, prog_fetch_strobe, port0_float, port2_addr_drive}, 8'h1f);
        rd(OFS_IRQ_ENABLE_MASK, 8'h81);
        irq(6'h01, 8'h08);
        irq(6'h00, 8'h00);
        wr(OFS_PM_CONTROL, 8'h01);
        @(posedge clk) hw_reset_req <= 1'b1;
        @(posedge clk) hw_reset_req <= 1'b0;
        #1 chk({6'h0, cpu_halt, ram_access_block}, 8'h01);
        for (n = 0; ram_access_block === 1'b1 && n < 100; n++) @(posedge clk) #1;
        chk(n[7:0], 8'h18);
        $display("idle done");
        wr(OFS_AUX_CONTROL, 8'h02);
        repeat (PDOWN_LOCKOUT_CYC) @(posedge clk);
        wr(OFS_PM_CONTROL, 8'h02);
        #1 chk({5'h0, osc_stop, ale_out, port0_float}, 8'h05);
        @(posedge clk) ext1_pin <= 1'b0;
        repeat (5) @(posedge clk);
        ext0_pin <= 1'b0;
        #1 chk({7'h0, osc_stop}, 8'h01);
        repeat (8) @(posedge clk);
        ext0_pin <= 1'b1;
        ext1_pin <= 1'b1;
        #1 chk({7'h0, cpu_halt}, 8'h01);
        repeat (3) @(posedge clk) #1;
        chk({7'h0, cpu_halt}, 8'h00);
        wr(OFS_AUX_CONTROL, 8'h00);
        repeat (PDOWN_LOCKOUT_CYC) @(posedge clk);
        wr(OFS_PM_CONTROL, 8'h02);
        @(posedge clk) ext0_pin <= 1'b0;
        for (n = 0; cpu_halt !== 1'b0 && n < 100; n++) @(posedge clk) #1;
        chk({7'h0, n >= 20 && n <= 22}, 8'h01);
        @(posedge clk) ext0_pin <= 1'b1;
        $display("power-down wake done");
        repeat (PDOWN_LOCKOUT_CYC) @(posedge clk);
        wr(OFS_PM_CONTROL, 8'h02);
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_IRQ_ENABLE_MASK, 8'h00);
        $display("power-down reset done");
        stop_test;
    end
    initial
    begin
        repeat (8000) @(posedge clk);
        err_count++;
        stop_test;
    end
endmodule
`default_nettype wire
